// ---- inc/msc_pkg.sv ----
// constants and types shared by the module sideband control block
package msc_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam longint CLK_HZ           = 50_000_000;
    localparam longint TURN_ON_MS       = 2000;
    localparam longint TURN_ON_CYCLES   = (TURN_ON_MS * CLK_HZ) / 1000;
    localparam longint RESET_PULSE_US   = 10;
    localparam longint RESET_PULSE_CYC  = (RESET_PULSE_US * CLK_HZ + 999_999) / 1_000_000;
    localparam longint SEL_ASSERT_US    = 2000;
    localparam longint SEL_DEASSERT_US  = 2000;
    localparam longint BUS_MAX_KHZ      = 400;
    localparam int     CNT_W            = 27;
    localparam logic [CNT_W-1:0] INIT_CYCLES_DEF = CNT_W'(TURN_ON_CYCLES);
    localparam logic [CNT_W-1:0] RESET_PULSE_CNT = CNT_W'(RESET_PULSE_CYC);

    // ------------------------------------------------------------------
    // serial bus addressing and reset values
    // ------------------------------------------------------------------
    localparam logic [6:0] DEV_ADDR           = 7'h50;
    localparam logic [7:0] USER_SETTING_RESET = 8'h00;
    localparam int         SYNC_LEN           = 4;
    localparam int         SYNC_RST_IDX       = 0;
    localparam int         SYNC_LP_IDX        = 1;
    localparam int         SYNC_RD_IDX        = 2;
    localparam int         SYNC_WR_IDX        = 3;
    localparam logic [SYNC_LEN-1:0] SYNC_RESET_VAL = 4'h1;

    // ------------------------------------------------------------------
    // status byte returned on every serial read
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [3:0] spare;
        logic       attention;
        logic       low_power;
        logic       fault;
        logic       data_not_ready;
    } msc_status_type;

    localparam msc_status_type STATUS_RESET = '{spare: 4'h0, attention: 1'b0,
                                                low_power: 1'b0, fault: 1'b0,
                                                data_not_ready: 1'b1};

    // ------------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        R_INIT  = 4'h1,
        R_READY = 4'h2,
        R_LOW   = 4'h4,
        R_HELD  = 4'h8
    } msc_rst_state_type;

    typedef enum logic [6:0] {
        B_IDLE  = 7'h01,
        B_ADDR  = 7'h02,
        B_AACK  = 7'h04,
        B_WDATA = 7'h08,
        B_WACK  = 7'h10,
        B_RDATA = 7'h20,
        B_RACK  = 7'h40
    } msc_bus_state_type;

endpackage

// ---- rtl/msc_top.sv ----
// sideband control of a pluggable module: presence, attention, select, reset
// ----------------------------------------------------------------------------
// Functional notes
// - presence output driven low while seated
// - attention output low on fault or completion
// - low power request only echoed in the status byte
// - selected module answers serial bus commands
// - deselected module never acknowledges bus traffic
// - undriven select reads as deselected
// - undriven reset input reads as released
// - long reset pulse restores all user defaults
// - completion interval starts at reset release
// - completion posts attention with not-ready cleared
// - power-up posts completion attention without reset
// - full operation within 2000 ms
// ----------------------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module msc_top
    import msc_pkg::*;
#(
    parameter logic [CNT_W-1:0] INIT_CYCLES = INIT_CYCLES_DEF
) (
    // system clock, reset, enable
    input  wire logic       SYS_CLK_IN,
    input  wire logic       RST_N_IN,
    input  wire logic       CLK_EN_IN,
    // host control pins
    input  wire logic       BUS_SELECT_N_IN,
    input  wire logic       MODULE_RESET_N_IN,
    input  wire logic       LOW_POWER_REQUEST_IN,
    // internal fault event, one-cycle pulse on SYS_CLK_IN
    input  wire logic       FAULT_IN,
    // two-wire serial bus
    input  wire logic       SCL_IN,
    input  wire logic       SDA_IN,
    output logic            SDA_OUT,
    output logic            SDA_OE_N_OUT,
    // status pins
    output logic            PRESENCE_OUT_N,
    output logic            ATTENTION_OUT_N,
    // user setting and readiness
    output logic [7:0]      USER_SETTING_OUT,
    output logic            DATA_NOT_READY_OUT
);

    // ------------------------------------------------------------------
    // system domain declarations
    // ------------------------------------------------------------------
    logic [SYNC_LEN-1:0] sync_a;
    logic [SYNC_LEN-1:0] sync_b;
    logic                rd_tog_seen;
    logic                wr_tog_seen;
    msc_rst_state_type   rst_state;
    msc_rst_state_type   next_rst_state;
    logic [CNT_W-1:0]    rst_cnt;
    logic [CNT_W-1:0]    next_rst_cnt;
    msc_status_type      status;
    logic [7:0]          user_setting;

    // ------------------------------------------------------------------
    // link domain declarations
    // ------------------------------------------------------------------
    logic                start_tog;
    logic                start_seen;
    logic                sda_rise;
    logic                sel_a;
    logic                sel_b;
    msc_status_type      stat_a;
    msc_status_type      stat_b;
    msc_bus_state_type   bus_state;
    logic [2:0]          bit_cnt;
    logic [6:0]          shift;
    logic [7:0]          tx;
    logic                rw;
    logic [7:0]          wr_byte;
    logic                rd_tog;
    logic                wr_tog;
    logic                sda_drive_n;

    // ------------------------------------------------------------------
    // system domain decode
    // ------------------------------------------------------------------
    wire logic [SYNC_LEN-1:0] pin_vec    = {wr_tog, rd_tog, LOW_POWER_REQUEST_IN,
                                           MODULE_RESET_N_IN};
    wire logic reset_pin_low = ~sync_b[SYNC_RST_IDX];
    wire logic status_read   = sync_b[SYNC_RD_IDX] ^ rd_tog_seen;
    wire logic byte_written  = sync_b[SYNC_WR_IDX] ^ wr_tog_seen;
    wire logic pulse_long    = (rst_cnt == RESET_PULSE_CNT);
    wire logic init_done     = (rst_cnt == INIT_CYCLES - CNT_W'(1));
    wire logic in_ready      = (rst_state == R_READY);
    wire logic in_init       = (rst_state == R_INIT);
    wire logic entering_held = (rst_state == R_LOW) & reset_pin_low & pulse_long;
    wire logic completing    = in_init & init_done;

    // ------------------------------------------------------------------
    // pin and cross-domain synchronisers
    // ------------------------------------------------------------------
    // reset starts in its released level; low power and both toggles start low
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sync_a <= SYNC_RESET_VAL;
            sync_b <= SYNC_RESET_VAL;
        end else if (CLK_EN_IN) begin
            sync_a <= pin_vec;
            sync_b <= sync_a;
        end
    end

    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rd_tog_seen <= 1'b0;
            wr_tog_seen <= 1'b0;
        end else if (CLK_EN_IN) begin
            rd_tog_seen <= sync_b[SYNC_RD_IDX];
            wr_tog_seen <= sync_b[SYNC_WR_IDX];
        end
    end

    // ------------------------------------------------------------------
    // reset sequencer
    // ------------------------------------------------------------------
    always_comb begin
        next_rst_state = rst_state;
        next_rst_cnt   = rst_cnt + CNT_W'(1);
        case (rst_state)
            R_INIT: begin
                if (reset_pin_low) begin
                    next_rst_state = R_LOW;
                    next_rst_cnt   = '0;
                end else if (init_done) begin
                    next_rst_state = R_READY;
                    next_rst_cnt   = '0;
                end
            end
            R_READY: begin
                next_rst_cnt = '0;
                if (reset_pin_low) begin
                    next_rst_state = R_LOW;
                end
            end
            R_LOW: begin
                // short glitch: go back to where the module was
                if (!reset_pin_low) begin
                    next_rst_state = status.data_not_ready ? R_INIT : R_READY;
                    next_rst_cnt   = '0;
                end else if (pulse_long) begin
                    next_rst_state = R_HELD;
                end
            end
            R_HELD: begin
                next_rst_cnt = '0;
                // interval counts from the rising edge
                if (!reset_pin_low) begin
                    next_rst_state = R_INIT;
                end
            end
            default: begin
                next_rst_state = R_INIT;
                next_rst_cnt   = '0;
            end
        endcase
    end

    // power-up enters the completion interval directly
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rst_state <= R_INIT;
            rst_cnt   <= '0;
        end else if (CLK_EN_IN) begin
            rst_state <= next_rst_state;
            rst_cnt   <= next_rst_cnt;
        end
    end

    // ------------------------------------------------------------------
    // status flags and user setting
    // ------------------------------------------------------------------
    // long pulse clears settings
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            user_setting <= USER_SETTING_RESET;
        end else if (CLK_EN_IN) begin
            if (entering_held) begin
                user_setting <= USER_SETTING_RESET;
            end else if (byte_written && in_ready) begin
                user_setting <= wr_byte;
            end
        end
    end

    // not-ready drops together with the attention post
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            status <= STATUS_RESET;
        end else if (CLK_EN_IN) begin
            // echoed for software only, steers nothing
            status.low_power <= sync_b[SYNC_LP_IDX];
            if (entering_held) begin
                status.data_not_ready <= 1'b1;
                status.fault          <= 1'b0;
                status.attention      <= 1'b0;
            end else begin
                if (completing) begin
                    status.data_not_ready <= 1'b0;
                end
                // set wins over the clearing read
                if (FAULT_IN) begin
                    status.fault <= 1'b1;
                end else if (status_read) begin
                    status.fault <= 1'b0;
                end
                if (FAULT_IN || completing) begin
                    status.attention <= 1'b1;
                end else if (status_read) begin
                    status.attention <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // status pins
    // ------------------------------------------------------------------
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            PRESENCE_OUT_N     <= 1'b0;
            ATTENTION_OUT_N    <= 1'b1;
            DATA_NOT_READY_OUT <= 1'b1;
            USER_SETTING_OUT   <= USER_SETTING_RESET;
        end else if (CLK_EN_IN) begin
            PRESENCE_OUT_N     <= 1'b0;
            ATTENTION_OUT_N    <= ~status.attention;
            DATA_NOT_READY_OUT <= status.data_not_ready;
            USER_SETTING_OUT   <= user_setting;
        end
    end

    // ------------------------------------------------------------------
    // link domain: start detection
    // ------------------------------------------------------------------
    // data falling while clock is high marks a start; clocked by the
    // data line since the bus clock is still high at that moment
    always_ff @(negedge SDA_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            start_tog <= 1'b0;
        end else if (SCL_IN) begin
            start_tog <= ~start_tog;
        end
    end

    always_ff @(posedge SCL_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sda_rise <= 1'b1;
        end else begin
            sda_rise <= SDA_IN;
        end
    end

    // ------------------------------------------------------------------
    // link domain: select and status crossing
    // ------------------------------------------------------------------
    // deselected until the pin is seen low
    always_ff @(negedge SCL_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            sel_a  <= 1'b1;
            sel_b  <= 1'b1;
            stat_a <= STATUS_RESET;
            stat_b <= STATUS_RESET;
        end else begin
            sel_a  <= BUS_SELECT_N_IN;
            sel_b  <= sel_a;
            stat_a <= status;
            stat_b <= stat_a;
        end
    end

    // ------------------------------------------------------------------
    // link domain: byte engine
    // ------------------------------------------------------------------
    wire logic       start_now = start_tog ^ start_seen;
    wire logic [7:0] rx_byte   = {shift, sda_rise};
    wire logic       selected  = ~sel_b;
    wire logic       addr_hit  = (rx_byte[7:1] == DEV_ADDR);
    wire logic       last_bit  = (bit_cnt == 3'h7);

    always_ff @(negedge SCL_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            start_seen  <= 1'b0;
            bus_state   <= B_IDLE;
            bit_cnt     <= 3'h0;
            shift       <= 7'h00;
            tx          <= 8'hFF;
            rw          <= 1'b0;
            wr_byte     <= 8'h00;
            rd_tog      <= 1'b0;
            wr_tog      <= 1'b0;
            sda_drive_n <= 1'b1;
        end else begin
            start_seen <= start_tog;
            bit_cnt    <= bit_cnt + 3'h1;
            shift      <= rx_byte[6:0];
            if (start_now) begin
                bus_state   <= B_ADDR;
                bit_cnt     <= 3'h0;
                sda_drive_n <= 1'b1;
            end else if (!selected) begin
                // deselected, release and ignore the frame
                bus_state   <= B_IDLE;
                sda_drive_n <= 1'b1;
            end else begin
                case (bus_state)
                    B_ADDR: begin
                        if (last_bit) begin
                            bus_state   <= addr_hit ? B_AACK : B_IDLE;
                            sda_drive_n <= ~addr_hit;
                            rw          <= rx_byte[0];
                        end
                    end
                    B_AACK, B_RACK: begin
                        bit_cnt <= 3'h0;
                        if ((bus_state == B_AACK && rw) ||
                            (bus_state == B_RACK && !sda_rise)) begin
                            // loading status counts as the read
                            tx          <= stat_b;
                            sda_drive_n <= stat_b[7];
                            rd_tog      <= ~rd_tog;
                            bus_state   <= B_RDATA;
                        end else begin
                            sda_drive_n <= 1'b1;
                            bus_state   <= (bus_state == B_AACK) ? B_WDATA : B_IDLE;
                        end
                    end
                    B_RDATA: begin
                        tx          <= {tx[6:0], 1'b1};
                        sda_drive_n <= last_bit ? 1'b1 : tx[6];
                        if (last_bit) begin
                            bus_state <= B_RACK;
                        end
                    end
                    B_WDATA: begin
                        if (last_bit) begin
                            wr_byte     <= rx_byte;
                            wr_tog      <= ~wr_tog;
                            sda_drive_n <= 1'b0;
                            bus_state   <= B_WACK;
                        end
                    end
                    B_WACK: begin
                        bit_cnt     <= 3'h0;
                        sda_drive_n <= 1'b1;
                        bus_state   <= B_WDATA;
                    end
                    default: begin
                        sda_drive_n <= 1'b1;
                        bus_state   <= B_IDLE;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // open-drain data pin
    // ------------------------------------------------------------------
    // level is always low; only the enable moves, so a glitch can only
    // release the line, never drive it high against another device
    always_ff @(negedge SCL_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            SDA_OUT <= 1'b0;
        end else begin
            SDA_OUT <= 1'b0;
        end
    end

    // enable is the engine's own flop: a second stage would move the ack
    // and every read bit one bus clock late
    assign SDA_OE_N_OUT = sda_drive_n;

endmodule

`default_nettype wire

// ---- verif/msc_host_model.sv ----
// two-wire bus master standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module msc_host_model #(
    parameter realtime HALF = 62.5
) (
    // scl driven push-pull, sda open-drain; released sda reads high
    output var logic scl_out,
    output var logic sda_oe_n_out,
    input  wire logic sda_in
);
    initial begin
        scl_out      = 1'h1;
        sda_oe_n_out = 1'h1;
    end
    // data moves mid low phase so it never looks like a start or stop
    task automatic bit_io(input logic b, output logic r);
        #(HALF / 2);
        sda_oe_n_out = b;
        #(HALF / 2);
        scl_out = 1'h1;
        #(HALF);
        r = sda_in;
        scl_out = 1'h0;
    endtask
    // scl stands high outside frames; reads end with a nack
    task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic ack,
                         output logic [7:0] q);
        logic r;
        sda_oe_n_out = 1'h0;
        #(HALF);
        scl_out = 1'h0;
        for (int i = 7; i >= 0; i--) bit_io(a[i], r);
        bit_io(1'h1, r);
        ack = ~r;
        for (int i = 7; i >= 0; i--) bit_io(a[0] | d[i], q[i]);
        bit_io(1'h1, r);
        #(HALF / 2);
        sda_oe_n_out = 1'h0;
        #(HALF / 2);
        scl_out = 1'h1;
        #(HALF / 2);
        sda_oe_n_out = 1'h1;
    endtask
endmodule
`default_nettype wire

// ---- verif/msc_properties.sv ----
// concurrent checks on the sideband control top ports
`timescale 1ns/10ps
`default_nettype none
module msc_properties
    import msc_pkg::*;
#(
    parameter logic [CNT_W-1:0] INIT_CYCLES = INIT_CYCLES_DEF
) (
    // clock, reset, host pins
    input wire logic       SYS_CLK_IN,
    input wire logic       RST_N_IN,
    input wire logic       CLK_EN_IN,
    input wire logic       BUS_SELECT_N_IN,
    input wire logic       MODULE_RESET_N_IN,
    input wire logic       LOW_POWER_REQUEST_IN,
    input wire logic       FAULT_IN,
    // serial bus and status
    input wire logic       SCL_IN,
    input wire logic       SDA_IN,
    input wire logic       SDA_OUT,
    input wire logic       SDA_OE_N_OUT,
    input wire logic       PRESENCE_OUT_N,
    input wire logic       ATTENTION_OUT_N,
    input wire logic [7:0] USER_SETTING_OUT,
    input wire logic       DATA_NOT_READY_OUT
);
    // ----------------------------------------
    // helper counters
    // ----------------------------------------
    logic [CNT_W-1:0] init_cnt;
    logic [10:0]      low_cnt;
    // frozen while disabled, as the design is
    always_ff @(posedge SYS_CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            init_cnt <= '0;
            low_cnt  <= '0;
        end else if (CLK_EN_IN) begin
            init_cnt <= (DATA_NOT_READY_OUT && MODULE_RESET_N_IN) ? init_cnt + 1'h1 : '0;
            low_cnt  <= MODULE_RESET_N_IN ? '0 : low_cnt + {10'h000, ~&low_cnt};
        end
    end
    presence_low_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        !PRESENCE_OUT_N) else $error("presence output released");
    fault_attn_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        FAULT_IN && CLK_EN_IN ##1 CLK_EN_IN |=> !ATTENTION_OUT_N) else $error("no attention");
    lp_ignored_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $changed(LOW_POWER_REQUEST_IN) |=> $stable(USER_SETTING_OUT)) else $error("lp effect");
    desel_quiet_a: assert property (@(negedge SCL_IN) disable iff (!RST_N_IN)
        BUS_SELECT_N_IN [*5] |-> SDA_OE_N_OUT) else $error("deselected module drove sda");
    long_reset_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $rose(MODULE_RESET_N_IN) && low_cnt > 11'h208 |-> DATA_NOT_READY_OUT
        && USER_SETTING_OUT == 8'h00) else $error("long reset not applied");
    short_reset_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $rose(MODULE_RESET_N_IN) && low_cnt < 11'h1E0 && !DATA_NOT_READY_OUT
        |-> !DATA_NOT_READY_OUT [*6]) else $error("short reset not ignored");
    init_max_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        init_cnt <= INIT_CYCLES + 8) else $error("completion interval too long");
    init_min_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $fell(DATA_NOT_READY_OUT) |-> init_cnt >= INIT_CYCLES) else $error("ready too early");
    done_attn_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $fell(DATA_NOT_READY_OUT) |-> !ATTENTION_OUT_N) else $error("no completion attention");
    attn_hold_a: assert property (@(posedge SYS_CLK_IN) disable iff (!RST_N_IN)
        $fell(ATTENTION_OUT_N) |-> !ATTENTION_OUT_N [*8]) else $error("attention dropped");
endmodule
`default_nettype wire

// ---- verif/msc_top_bench.sv ----
// self-checking bench for the module sideband control block
`timescale 1ns/10ps
`default_nettype none
module msc_top_bench;
    import msc_pkg::*;
    localparam logic [CNT_W-1:0] INIT_CYCLES = 27'h00000C8;
    localparam int SEL_GAP = 20;
    typedef struct packed {
        logic sel_n; logic lp; logic [7:0] a; logic [7:0] d;
        logic ack; logic [7:0] q; logic [7:0] setv; logic att_n;
    } msc_row_type;
    logic       sys_clk, rst_n, clk_en, sel_n, mod_rst_n, lp_req, fault;
    logic       scl, host_oe_n, sda_out, sda_oe_n, presence_n, attn_n, dnr;
    logic [7:0] setting;
    wire logic  sda_w;
    int         failures = 0;
    int         samples_checked = 0;
    msc_row_type rows [9] = '{
        '{1'h0, 1'h0, 8'hA2, 8'h77, 1'h0, 8'h77, 8'h00, 1'h0},
        '{1'h0, 1'h0, 8'hA1, 8'h00, 1'h1, 8'h08, 8'h00, 1'h0},
        '{1'h0, 1'h0, 8'hA1, 8'h00, 1'h1, 8'h00, 8'h00, 1'h1},
        '{1'h0, 1'h1, 8'hA0, 8'h5A, 1'h1, 8'h5A, 8'h5A, 1'h1},
        '{1'h0, 1'h1, 8'hA1, 8'h00, 1'h1, 8'h04, 8'h5A, 1'h1},
        '{1'h1, 1'h0, 8'hA0, 8'h33, 1'h0, 8'h33, 8'h5A, 1'h1},
        '{1'h1, 1'h0, 8'hA1, 8'h00, 1'h0, 8'hFF, 8'h5A, 1'h1},
        '{1'h0, 1'h0, 8'hA2, 8'h77, 1'h0, 8'h77, 8'h5A, 1'h1},
        '{1'h0, 1'h0, 8'hA0, 8'hC3, 1'h1, 8'hC3, 8'hC3, 1'h1}};
    // write rows read back the host's own data: the module must not pull it low
    // wired-and of both open-drain drivers over the pull-up
    assign sda_w = host_oe_n & (sda_oe_n | sda_out);
    msc_top #(.INIT_CYCLES(INIT_CYCLES)) i_msc_top (
        .SYS_CLK_IN(sys_clk), .RST_N_IN(rst_n), .CLK_EN_IN(clk_en), .BUS_SELECT_N_IN(sel_n),
        .MODULE_RESET_N_IN(mod_rst_n), .LOW_POWER_REQUEST_IN(lp_req), .FAULT_IN(fault),
        .SCL_IN(scl), .SDA_IN(sda_w), .SDA_OUT(sda_out), .SDA_OE_N_OUT(sda_oe_n),
        .PRESENCE_OUT_N(presence_n), .ATTENTION_OUT_N(attn_n), .USER_SETTING_OUT(setting),
        .DATA_NOT_READY_OUT(dnr));
    msc_host_model i_msc_host_model (.scl_out(scl), .sda_oe_n_out(host_oe_n), .sda_in(sda_w));
    initial begin
        sys_clk = 1'h0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic close_out();
        $display("checked %0d, failed %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        chk8({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wait_ready();
        int n;
        n = 0;
        while (dnr !== 1'h0 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        if (dnr !== 1'h0) begin
            failures++;
            close_out();
        end
    endtask
    task automatic do_reset();
        rst_n = 1'h0;
        repeat (10) @(negedge sys_clk);
        chk1(presence_n, 1'h0);
        chk1(attn_n, 1'h1);
        chk1(dnr, 1'h1);
        chk8(setting, 8'h00);
        rst_n = 1'h1;
        wait_ready();
        chk1(attn_n, 1'h0);
    endtask
    task automatic xfer(input logic s, input logic [7:0] a, d, input logic k,
                        input logic [7:0] q);
        logic       ack;
        logic [7:0] rd;
        @(negedge sys_clk);
        sel_n = s;
        repeat (SEL_GAP) @(negedge sys_clk);
        i_msc_host_model.frame(a, d, ack, rd);
        chk1(ack, k);
        chk8(rd, q);
    endtask
    initial begin
        // reset low, clock enabled, deselected, module reset released
        {rst_n, clk_en, sel_n, mod_rst_n, lp_req, fault} = 6'h1C;
        @(negedge sys_clk);
        do_reset();
        foreach (rows[k]) begin
            chk1(attn_n, rows[k].att_n);
            lp_req = rows[k].lp;
            xfer(rows[k].sel_n, rows[k].a, rows[k].d, rows[k].ack, rows[k].q);
            repeat (8) @(negedge sys_clk);
            chk8(setting, rows[k].setv);
        end
        // a fault pulse while frozen must leave attention untouched
        clk_en = 1'h0;
        fault = 1'h1;
        @(negedge sys_clk);
        fault = 1'h0;
        repeat (4) @(negedge sys_clk);
        chk1(attn_n, 1'h1);
        clk_en = 1'h1;
        fault = 1'h1;
        @(negedge sys_clk);
        fault = 1'h0;
        repeat (2) @(negedge sys_clk);
        chk1(attn_n, 1'h0);
        xfer(1'h0, 8'hA1, 8'h00, 1'h1, 8'h0A);
        repeat (8) @(negedge sys_clk);
        chk1(attn_n, 1'h1);
        mod_rst_n = 1'h0;
        repeat (100) @(negedge sys_clk);
        mod_rst_n = 1'h1;
        repeat (10) @(negedge sys_clk);
        chk8(setting, 8'hC3);
        mod_rst_n = 1'h0;
        repeat (600) @(negedge sys_clk);
        chk8(setting, 8'h00);
        mod_rst_n = 1'h1;
        // interval counts from release, so far longer low must not shorten it
        repeat (100) @(negedge sys_clk);
        chk1(dnr, 1'h1);
        wait_ready();
        chk1(attn_n, 1'h0);
        xfer(1'h0, 8'hA1, 8'h00, 1'h1, 8'h08);
        do_reset();
        close_out();
    end
endmodule
bind msc_top msc_properties #(.INIT_CYCLES(INIT_CYCLES)) i_msc_properties (
    .SYS_CLK_IN(SYS_CLK_IN), .RST_N_IN(RST_N_IN), .CLK_EN_IN(CLK_EN_IN),
    .BUS_SELECT_N_IN(BUS_SELECT_N_IN), .MODULE_RESET_N_IN(MODULE_RESET_N_IN),
    .LOW_POWER_REQUEST_IN(LOW_POWER_REQUEST_IN), .FAULT_IN(FAULT_IN), .SCL_IN(SCL_IN),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE_N_OUT(SDA_OE_N_OUT),
    .PRESENCE_OUT_N(PRESENCE_OUT_N), .ATTENTION_OUT_N(ATTENTION_OUT_N),
    .USER_SETTING_OUT(USER_SETTING_OUT), .DATA_NOT_READY_OUT(DATA_NOT_READY_OUT));
`default_nettype wire
